// >>> common/sdpci_pkg.sv
// Package with constants and carrier types of the SDRAM pin command interface.
// How it works
// - Row uses 12 address bits, column 8.
// - Precharge all banks when flag bit set.
// - Bank select picks activated or accessed bank.
// - Data lines are bidirectional, never contended.
// - Chip select off ignores commands, ops continue.
// - Strobes decode operation at rising edge.
// - Read mask tristates byte two cycles later.
// - Write mask blocks byte write immediately.
// - Inputs sampled only on rising clock edge.
// - Clock gate low enters low-power modes.
// - Four masks, one per byte lane.
// - All strobes low means mode register set.
package sdpci_pkg;
  localparam int ROW_W         = 12;
  localparam int COL_W         = 8;
  localparam int ADDR_W        = 12;
  localparam int BANK_W        = 2;
  localparam int NBANK         = 4;
  localparam int DATA_W        = 32;
  localparam int NLANE         = 4;
  localparam int ALL_BANKS_BIT = 10;
  localparam int READ_MASK_LAT = 2;
  localparam int CAS_LAT       = 3;
  localparam int MEM_DEPTH     = 16;
  localparam int MEM_AW        = 4;

  typedef enum logic [2:0] {
    SDPCI_CMD_MRS  = 3'h0,
    SDPCI_CMD_REF  = 3'h1,
    SDPCI_CMD_PRE  = 3'h2,
    SDPCI_CMD_ACT  = 3'h3,
    SDPCI_CMD_WR   = 3'h4,
    SDPCI_CMD_RD   = 3'h5,
    SDPCI_CMD_BST  = 3'h6,
    SDPCI_CMD_NOP  = 3'h7
  } sdpci_cmd_e;

  typedef enum logic [1:0] {
    SDPCI_PWR_RUN     = 2'b00,
    SDPCI_PWR_SUSPEND = 2'b01,
    SDPCI_PWR_DOWN    = 2'b11,
    SDPCI_PWR_SELFREF = 2'b10
  } sdpci_pwr_e;

  typedef struct packed {
    logic                 cs_n;
    logic                 ras_n;
    logic                 cas_n;
    logic                 we_n;
    logic [BANK_W-1:0]    bank_select_bits;
    logic [ADDR_W-1:0]    addr;
  } sdpci_cmd_s;
endpackage

// >>> design/sdpci_decode.sv
// Command decoder that maps the strobe levels to an operation.
module sdpci_decode (
  // Sampled command pins
  input  wire sdpci_pkg::sdpci_cmd_s cmd_i,
  input  wire logic                  clk_en_i,
  // Decoded operation
  output logic [2:0]                 op_o,
  output logic                       valid_o
);
  // The strobes directly form the operation code; chip select gates validity.
  assign op_o    = {cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n};
  assign valid_o = ~cmd_i.cs_n & clk_en_i;
endmodule

// >>> design/sdpci_top.sv
// Device side pin command interface of a four bank 32 bit SDRAM.
module sdpci_top (
  // Clock and reset
  input  wire logic                         core_clk_i,
  input  wire logic                         reset_i,
  // Command and address pins
  input  wire sdpci_pkg::sdpci_cmd_s        cmd_i,
  input  wire logic                         clk_gate_i,
  input  wire logic [sdpci_pkg::NLANE-1:0]  byte_mask_i,
  // Data lines, three signals
  input  wire logic [sdpci_pkg::DATA_W-1:0] data_lines_i,
  output logic [sdpci_pkg::DATA_W-1:0]      data_lines_o,
  output logic [sdpci_pkg::DATA_W-1:0]      data_lines_oe_n_o,
  // Status
  output logic [sdpci_pkg::NBANK-1:0]       bank_open_o,
  output logic [1:0]                        pwr_state_o,
  output logic [sdpci_pkg::ADDR_W-1:0]      mode_reg_o
);
  localparam int LAT = sdpci_pkg::CAS_LAT;

  logic [2:0] op;
  logic       op_valid;
  logic       clk_gate_q;
  logic [sdpci_pkg::NBANK-1:0]  bank_open;
  logic [sdpci_pkg::ROW_W-1:0]  open_row [sdpci_pkg::NBANK];
  logic [sdpci_pkg::DATA_W-1:0] mem [sdpci_pkg::MEM_DEPTH];
  logic [LAT-1:0]               rd_pipe;
  logic [sdpci_pkg::DATA_W-1:0] rd_data [LAT];
  logic [sdpci_pkg::NLANE-1:0]  mask_q1;
  logic                         wr_burst;
  logic [sdpci_pkg::MEM_AW-1:0] wr_idx;
  sdpci_pkg::sdpci_pwr_e        pwr;

  sdpci_decode u_dec (
    .cmd_i    (cmd_i),
    .clk_en_i (clk_gate_q),
    .op_o     (op),
    .valid_o  (op_valid)
  );

  // Memory index from bank and low column bits.
  function automatic logic [sdpci_pkg::MEM_AW-1:0] mem_idx(
    input logic [sdpci_pkg::BANK_W-1:0] b, input logic [sdpci_pkg::ADDR_W-1:0] a);
    mem_idx = {b, a[1:0]};
  endfunction

  wire is_act = op_valid && op == sdpci_pkg::SDPCI_CMD_ACT;
  wire is_rd  = op_valid && op == sdpci_pkg::SDPCI_CMD_RD;
  wire is_wr  = op_valid && op == sdpci_pkg::SDPCI_CMD_WR;
  wire is_pre = op_valid && op == sdpci_pkg::SDPCI_CMD_PRE;
  wire is_mrs = op_valid && op == sdpci_pkg::SDPCI_CMD_MRS;
  wire is_ref = op_valid && op == sdpci_pkg::SDPCI_CMD_REF;
  wire [sdpci_pkg::COL_W-1:0] col = cmd_i.addr[sdpci_pkg::COL_W-1:0];
  wire [sdpci_pkg::MEM_AW-1:0] acc_idx = mem_idx(cmd_i.bank_select_bits,
                                                 {4'h0, col});
  wire wr_now = is_wr && bank_open[cmd_i.bank_select_bits];
  wire [sdpci_pkg::MEM_AW-1:0] wr_at = wr_now ? acc_idx : wr_idx;
  wire wr_go = (wr_now || (wr_burst && !is_rd)) && clk_gate_q;

  // Power state follows the clock gate, refresh commands and read or write burst activity.
  sdpci_pkg::sdpci_pwr_e next_pwr;
  always_comb begin
    next_pwr = sdpci_pkg::SDPCI_PWR_RUN;
    if (!clk_gate_i) begin
      if (pwr != sdpci_pkg::SDPCI_PWR_RUN) next_pwr = pwr;
      else if (is_ref) next_pwr = sdpci_pkg::SDPCI_PWR_SELFREF;
      else if (|rd_pipe || wr_burst) next_pwr = sdpci_pkg::SDPCI_PWR_SUSPEND;
      else next_pwr = sdpci_pkg::SDPCI_PWR_DOWN;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pwr        <= sdpci_pkg::SDPCI_PWR_RUN;
      clk_gate_q <= 1'b1;
    end else begin
      pwr        <= next_pwr;
      clk_gate_q <= clk_gate_i;
    end
  end

  // Bank open state and rows.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      bank_open <= '0;
      for (int i = 0; i < sdpci_pkg::NBANK; i++) open_row[i] <= '0;
    end else if (is_act) begin
      bank_open[cmd_i.bank_select_bits] <= 1'b1;
      open_row[cmd_i.bank_select_bits]  <= cmd_i.addr[sdpci_pkg::ROW_W-1:0];
    end else if (is_pre) begin
      if (cmd_i.addr[sdpci_pkg::ALL_BANKS_BIT]) bank_open <= '0;
      else bank_open[cmd_i.bank_select_bits] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) mode_reg_o <= '0;
    else if (is_mrs) mode_reg_o <= cmd_i.addr;
  end

  // Write path: masked lanes are blocked in the cycle they are sampled.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wr_burst <= 1'b0;
      wr_idx   <= '0;
    end else begin
      if (wr_go) begin
        for (int l = 0; l < sdpci_pkg::NLANE; l++)
          if (!byte_mask_i[l]) mem[wr_at][l*8 +: 8] <= data_lines_i[l*8 +: 8];
      end
      if (is_rd || is_pre) wr_burst <= 1'b0;
      else if (wr_now) wr_burst <= 1'b1;
      if (wr_go) wr_idx <= wr_at + 4'h1;
    end
  end

  // Read path: data after the latency, lanes masked two cycles on.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rd_pipe <= '0;
      mask_q1 <= '1;
      for (int i = 0; i < LAT; i++) rd_data[i] <= '0;
    end else begin
      rd_pipe <= {rd_pipe[LAT-2:0], is_rd && bank_open[cmd_i.bank_select_bits]};
      rd_data[0] <= mem[acc_idx];
      for (int i = 1; i < LAT; i++) rd_data[i] <= rd_data[i-1];
      mask_q1 <= byte_mask_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      data_lines_o      <= '0;
      data_lines_oe_n_o <= '1;
    end else begin
      data_lines_o <= rd_data[LAT-2];
      for (int l = 0; l < sdpci_pkg::NLANE; l++)
        data_lines_oe_n_o[l*8 +: 8] <= {8{!(rd_pipe[LAT-2] && !mask_q1[l])}};
    end
  end

  assign bank_open_o = bank_open;
  assign pwr_state_o = pwr;

  // Assertions.
  property p_rd_mask;
    @(posedge core_clk_i) disable iff (reset_i)
      byte_mask_i[0] |-> ##2 data_lines_oe_n_o[0];
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("masked lane driven");

  property p_idle_hiz;
    @(posedge core_clk_i) disable iff (reset_i)
      !rd_pipe[LAT-2] |=> &data_lines_oe_n_o;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("drivers on when idle");

  property p_pre_all;
    @(posedge core_clk_i) disable iff (reset_i)
      is_pre && cmd_i.addr[sdpci_pkg::ALL_BANKS_BIT] |=> bank_open == '0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all failed");

  property p_cs_ignore;
    @(posedge core_clk_i) disable iff (reset_i)
      cmd_i.cs_n |=> $stable(bank_open) && $stable(mode_reg_o);
  endproperty
  a_cs_ignore: assert property (p_cs_ignore) else $error("deselected command acted");

  property p_act;
    @(posedge core_clk_i) disable iff (reset_i)
      is_act |=> bank_open[$past(cmd_i.bank_select_bits)];
  endproperty
  a_act: assert property (p_act) else $error("activate did not open bank");

  property p_act_row;
    @(posedge core_clk_i) disable iff (reset_i)
      is_act |=> open_row[$past(cmd_i.bank_select_bits)]
                 == $past(cmd_i.addr[sdpci_pkg::ROW_W-1:0]);
  endproperty
  a_act_row: assert property (p_act_row) else $error("row address not latched");

  property p_mrs;
    @(posedge core_clk_i) disable iff (reset_i)
      is_mrs |=> mode_reg_o == $past(cmd_i.addr);
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode register not loaded");

  sequence s_rd_issue;
    is_rd && bank_open[cmd_i.bank_select_bits] && !byte_mask_i[0] ##1 !byte_mask_i[0];
  endsequence
  // The read launches after the second edge past the command, seen at the third.
  property p_rd_lat;
    @(posedge core_clk_i) disable iff (reset_i)
      s_rd_issue |-> ##2 !data_lines_oe_n_o[0];
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");

  property p_pwr;
    @(posedge core_clk_i) disable iff (reset_i)
      clk_gate_i |=> pwr == sdpci_pkg::SDPCI_PWR_RUN;
  endproperty
  a_pwr: assert property (p_pwr) else $error("not running with gate high");
endmodule

// >>> tb/sdpci_ctrl_model.sv
// Controller side of the shared data lines, resolving who drives each bit.
module sdpci_ctrl_model (
  // Clock
  input  wire logic        core_clk_i,
  // Device side of the data lines
  input  wire logic [31:0] dev_data_i,
  input  wire logic [31:0] dev_oe_n_i,
  // Controller write data
  input  wire logic [31:0] ctrl_data_i,
  input  wire logic        ctrl_drive_i,
  // Resolved wire
  output logic [31:0]      bus_o,
  output logic             clash_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last;
  // An undriven bit shows the inverse of its last level, so it toggles every cycle while left undriven.
  assign bus_o = (~dev_oe_n_i & dev_data_i) | (dev_oe_n_i & {32{ctrl_drive_i}} & ctrl_data_i)
               | (dev_oe_n_i & {32{~ctrl_drive_i}} & ~last);
  assign clash_o = ctrl_drive_i & ~(&dev_oe_n_i);
  always_ff @(posedge core_clk_i) begin
    last <= bus_o;
  end
endmodule

// >>> tb/tb_sdpci_top.sv
// Self-checking bench of the SDRAM pin command interface.
module tb_sdpci_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  core_clk_i = 1'b0;
  logic                  reset_i    = 1'b1;
  logic                  gate       = 1'b1;
  logic                  drv        = 1'b0;
  logic [3:0]            mask       = 4'h0;
  logic [31:0]           wdata      = 32'h0000_0000;
  sdpci_pkg::sdpci_cmd_s cmd        = {4'h7, 2'h0, 12'h000};
  logic [31:0]           bus, dout, oe_n;
  logic [3:0]            bank_open;
  logic [1:0]            pwr;
  logic [11:0]           mode;
  logic                  clash;
  int                    num_errors = 0;
  int                    n_checks   = 0;
  int                    cyc        = 0;

  always #2.5 core_clk_i = ~core_clk_i;

  sdpci_top uut (.core_clk_i(core_clk_i), .reset_i(reset_i), .cmd_i(cmd), .clk_gate_i(gate),
    .byte_mask_i(mask), .data_lines_i(bus), .data_lines_o(dout), .data_lines_oe_n_o(oe_n),
    .bank_open_o(bank_open), .pwr_state_o(pwr), .mode_reg_o(mode));
  sdpci_ctrl_model ctrl (.core_clk_i(core_clk_i), .dev_data_i(dout), .dev_oe_n_i(oe_n),
    .ctrl_data_i(wdata), .ctrl_drive_i(drv), .bus_o(bus), .clash_o(clash));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Strobe code is {cs_n, ras_n, cas_n, we_n}; the command is sampled at the following edge.
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                       input logic [3:0] m, input logic d, input logic [31:0] w);
    @(posedge core_clk_i);
    cmd   <= {c, b, a};
    mask  <= m;
    drv   <= d;
    wdata <= w;
  endtask

  task automatic nop(input logic [3:0] m);
    issue(4'h7, 2'h0, 12'h000, m, 1'b0, 32'h0000_0000);
  endtask

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors++;
      end_sim();
    end
  end

  always @(negedge core_clk_i) begin
    if (!reset_i) begin
      chk("data line contention", clash, 1'b0);
    end
  end

  initial begin
    repeat (3) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("oe_n at reset", oe_n, 32'hffff_ffff);
    chk("banks at reset", bank_open, 4'h0);
    chk("power at reset", pwr, 2'b00);
    @(posedge core_clk_i);
    reset_i <= 1'b0;
    issue(4'h0, 2'h0, 12'h0a5, 4'h0, 1'b0, 32'h0);
    issue(4'h8, 2'h0, 12'h03c, 4'h0, 1'b0, 32'h0);
    nop(4'h0);
    @(negedge core_clk_i);
    chk("mode register", mode, 12'h0a5);
    issue(4'h3, 2'h1, 12'hfff, 4'h0, 1'b0, 32'h0);
    issue(4'h3, 2'h2, 12'h123, 4'h0, 1'b0, 32'h0);
    issue(4'h4, 2'h1, 12'h000, 4'h0, 1'b1, 32'h1111_2222);
    issue(4'h4, 2'h1, 12'h000, 4'h2, 1'b1, 32'h3333_4444);
    nop(4'hf);
    @(negedge core_clk_i);
    chk("open banks", bank_open, 4'h6);
    chk("oe_n in write", oe_n, 32'hffff_ffff);
    issue(4'h5, 2'h1, 12'h000, 4'h4, 1'b0, 32'h0);
    repeat (3) nop(4'h4);
    @(negedge core_clk_i);
    chk("read oe_n", oe_n, 32'h00ff_0000);
    chk("read data", dout & 32'hff00_ffff, 32'h3300_2244);
    chk("read bus", bus & 32'hff00_ffff, 32'h3300_2244);
    @(negedge core_clk_i);
    chk("oe_n after read", oe_n, 32'hffff_ffff);
    issue(4'h2, 2'h1, 12'h000, 4'h0, 1'b0, 32'h0);
    nop(4'h0);
    @(negedge core_clk_i);
    chk("single precharge", bank_open, 4'h4);
    issue(4'h3, 2'h1, 12'h000, 4'h0, 1'b0, 32'h0);
    issue(4'h2, 2'h0, 12'h400, 4'h0, 1'b0, 32'h0);
    nop(4'h0);
    @(negedge core_clk_i);
    chk("all precharge", bank_open, 4'h0);
    @(posedge core_clk_i);
    gate <= 1'b0;
    issue(4'h0, 2'h0, 12'h5a0, 4'h0, 1'b0, 32'h0);
    nop(4'h0);
    @(negedge core_clk_i);
    chk("power down entered", pwr, 2'b11);
    chk("mode while gated", mode, 12'h0a5);
    @(posedge core_clk_i);
    gate <= 1'b1;
    nop(4'h0);
    nop(4'h0);
    @(negedge core_clk_i);
    chk("power run", pwr, 2'b00);
    issue(4'h1, 2'h0, 12'h000, 4'h0, 1'b0, 32'h0);
    gate <= 1'b0;
    nop(4'h0);
    @(negedge core_clk_i);
    chk("self refresh entered", pwr, 2'b10);
    @(posedge core_clk_i);
    gate <= 1'b1;
    issue(4'h3, 2'h0, 12'h000, 4'h0, 1'b0, 32'h0);
    issue(4'h4, 2'h0, 12'h000, 4'hf, 1'b1, 32'h5555_6666);
    nop(4'hf);
    gate <= 1'b0;
    nop(4'hf);
    @(negedge core_clk_i);
    chk("clock suspend entered", pwr, 2'b01);
    end_sim();
  end
endmodule
